// [rtl/scs_cfg.svh]
// Register offsets, field positions, reset values and timing counts for the serial port control block
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
// ------------------------------------------------------------
// Special-function addresses
// ------------------------------------------------------------
`define SCS_ADDR_CTRL      8'hF8
`define SCS_ADDR_CFG       8'hA1
`define SCS_ADDR_DATA      8'hA3
// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define SCS_BIT_DONE       7
`define SCS_BIT_WRITE_COLLISION_FLAG       6
`define SCS_BIT_MFLT       5
`define SCS_BIT_OVRN       4
`define SCS_BIT_MODE_HI    3
`define SCS_BIT_MODE_LO    2
`define SCS_BIT_TXE        1
`define SCS_BIT_EN         0
// ------------------------------------------------------------
// Configuration register field positions
// ------------------------------------------------------------
`define SCS_BIT_MASTER     6
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SCS_RST_MODE       2'h1
`define SCS_RST_DATA       8'h00
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SCS_SYNC_STAGES    2
`endif

// [rtl/scs_pkg.sv]
// Types shared by the serial port control block
package scs_pkg;
    // Slave-select pin modes
    typedef enum logic [1:0] {
        SCS_MODE_THREE_WIRE = 2'h0,
        SCS_MODE_FOUR_SLAVE = 2'h1,
        SCS_MODE_DRIVE_LOW  = 2'h2,
        SCS_MODE_DRIVE_HIGH = 2'h3
    } scs_mode_e;
    // Events handed from the link domain to the system domain
    typedef struct packed {
        logic done;     // Byte transfer finished
        logic last_bit; // Final bit entered the shift register
        logic load;     // Transmit byte moved to shifter
    } scs_link_evt_s;
    // Processor special-function bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scs_sfr_req_s;
endpackage

// [rtl/scs_evt_sync.sv]
// Toggle-based event crossing from the link clock into the system clock
`timescale 1ns/10ps
module scs_evt_sync (
    // Source side
    input  wire logic link_clk,
    input  wire logic link_rst_n,
    input  wire logic src_pulse,
    // Destination side
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      dst_pulse
);
    // ------------------------------------------------------------
    // Source toggle
    // ------------------------------------------------------------
    logic src_tgl_q; // Flips once per event
    logic s1_q;      // First stage, read only by s2_q
    logic s2_q;      // Second stage
    logic s3_q;      // Edge history

    // Toggle on every event so no pulse is narrower than a slow clock
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            src_tgl_q <= 1'b0;
        end else if (src_pulse) begin
            src_tgl_q <= ~src_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Destination synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            dst_pulse <= 1'b0;
        end else begin
            s1_q      <= src_tgl_q;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            dst_pulse <= s2_q ^ s3_q;
        end
    end
endmodule

// [rtl/scs_ctrl.sv]
// Control and status register logic of the byte-wide serial port
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_ctrl (
    // System clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Link clock and reset
    input  wire logic                 link_clk,
    input  wire logic                 link_rst_n,
    // Processor special-function bus
    input  wire scs_pkg::scs_sfr_req_s sfr_req,
    output logic [7:0]                sfr_rdata,
    // Interrupt enable from the core's interrupt controller
    input  wire logic                 irq_enable,
    output logic                      irq,
    // Events from the shift engine, link domain
    input  wire scs_pkg::scs_link_evt_s link_evt,
    input  wire logic [7:0]           link_rx_byte,
    // Slave-select pin
    input  wire logic                 slave_select_pin_i,
    output logic                      slave_select_pin_o,
    output logic                      slave_select_pin_oe,
    // To the shift engine
    output logic                      port_enable,
    output logic                      master_enable,
    output logic [7:0]                tx_byte,
    output logic                      tx_valid
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic       done_q;        // Transfer complete flag
    logic       write_collision_flag_q;        // Write collision flag
    logic       mflt_q;        // Mode fault flag
    logic       ovrn_q;        // Receive overrun flag
    logic [1:0] mode_q;        // Slave-select pin mode
    logic       txe_q;         // Transmit buffer empty
    logic       tx_full_q;     // Transmit buffer holds a byte
    logic       en_q;          // Port enable
    logic       mst_q;         // Master enable
    logic [7:0] txbuf_q;       // Transmit buffer
    logic [7:0] rxbuf_q;       // Receive buffer
    logic       rx_full_q;     // Receive buffer holds unread data
    logic [7:0] rdata_q;       // Registered read data
    logic       irq_q;         // Registered interrupt
    logic       ss_o_q;        // Pin output value
    logic       ss_oe_q;       // Pin output enable
    logic       ss_s1_q;       // Pin synchroniser first stage
    logic       ss_s2_q;       // Pin synchroniser second stage
    logic [7:0] rx_hold_q;     // Received byte held in link domain

    // ------------------------------------------------------------
    // Event crossings from the link clock
    // ------------------------------------------------------------
    // Three independent crossings; the link side spaces its events far
    // enough apart that each toggle settles before the next one
    logic ev_done;  // Byte finished, system domain pulse
    logic ev_last;  // Last bit in, system domain pulse
    logic ev_load;  // Shifter took transmit byte

    scs_evt_sync u_sync_done (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .src_pulse  (link_evt.done),
        .clk        (clk),
        .reset_n    (reset_n),
        .dst_pulse  (ev_done)
    );
    scs_evt_sync u_sync_last (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .src_pulse  (link_evt.last_bit),
        .clk        (clk),
        .reset_n    (reset_n),
        .dst_pulse  (ev_last)
    );
    scs_evt_sync u_sync_load (
        .link_clk   (link_clk),
        .link_rst_n (link_rst_n),
        .src_pulse  (link_evt.load),
        .clk        (clk),
        .reset_n    (reset_n),
        .dst_pulse  (ev_load)
    );

    // Received byte is captured at the end of the byte and stays stable
    // for many link cycles, so the done pulse qualifies it safely
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_hold_q <= `SCS_RST_DATA;
        end else if (link_evt.done) begin
            rx_hold_q <= link_rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Strobes last one cycle; a write takes effect at the next edge
    wire wr_ctrl  = sfr_req.wr && (sfr_req.addr == `SCS_ADDR_CTRL);
    wire wr_cfg   = sfr_req.wr && (sfr_req.addr == `SCS_ADDR_CFG);
    wire wr_data  = sfr_req.wr && (sfr_req.addr == `SCS_ADDR_DATA);
    wire rd_data  = sfr_req.rd && (sfr_req.addr == `SCS_ADDR_DATA);
    // A data write only lands while the buffer is empty
    wire data_ok  = wr_data && txe_q;
    wire data_bad = wr_data && !txe_q;
    wire [7:0] wd = sfr_req.wdata;

    // ------------------------------------------------------------
    // Mode fault detection
    // ------------------------------------------------------------
    // Mode 0 never looks at the pin, so a floating pin is harmless
    // Synchronised pin, only the second stage feeds logic
    wire ss_low    = !ss_s2_q;
    wire multi_mst = (mode_q == scs_pkg::SCS_MODE_FOUR_SLAVE);
    wire fault_ev  = en_q && mst_q && multi_mst && ss_low;

    // ------------------------------------------------------------
    // Flag next values: set beats a firmware clear in the same cycle
    // ------------------------------------------------------------
    // Writing 1 to a flag bit sets it, as a plain read-write field
    wire done_d = ev_done  | (wr_ctrl ? wd[`SCS_BIT_DONE] : done_q);
    wire write_collision_flag_d = data_bad | (wr_ctrl ? wd[`SCS_BIT_WRITE_COLLISION_FLAG] : write_collision_flag_q);
    wire mflt_d = fault_ev | (wr_ctrl ? wd[`SCS_BIT_MFLT] : mflt_q);
    wire ovrn_ev = ev_last && rx_full_q;
    wire ovrn_d = ovrn_ev  | (wr_ctrl ? wd[`SCS_BIT_OVRN] : ovrn_q);

    // Buffer empty: load clears it, transfer to shifter sets it
    wire txe_d = data_ok ? 1'b0 : (ev_load ? 1'b1 : txe_q);

    // Receive buffer holds until read; a new byte overwrites it
    // A read in the cycle of a new byte loses, so the byte stays unread
    wire rx_full_d = ev_done ? 1'b1 : (rd_data ? 1'b0 : rx_full_q);

    // ------------------------------------------------------------
    // Pin control per slave-select mode
    // ------------------------------------------------------------
    // Modes 0 and 1 release the pin; a disabled port never drives it,
    // so a part held off cannot fight another master on the line
    wire drive_pin = en_q && mode_q[1];
    wire pin_level = (mode_q == scs_pkg::SCS_MODE_DRIVE_HIGH);

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    // Read data follows the address every cycle; only a data port read
    // has a side effect, taking down the unread marker
    wire [7:0] ctrl_view = {done_q, write_collision_flag_q, mflt_q, ovrn_q, mode_q, txe_q, en_q};
    wire [7:0] cfg_view  = {1'b0, mst_q, 6'h00};
    wire [7:0] rd_mux    = (sfr_req.addr == `SCS_ADDR_CTRL) ? ctrl_view :
                           (sfr_req.addr == `SCS_ADDR_CFG)  ? cfg_view  :
                           (sfr_req.addr == `SCS_ADDR_DATA) ? rxbuf_q   : 8'h00;

    // Interrupt is the enabled OR of all four sticky flags
    // Registered, so the request follows a flag by one cycle
    wire irq_d = irq_enable && (done_q | write_collision_flag_q | mflt_q | ovrn_q);

    // ------------------------------------------------------------
    // Sticky flags and buffer state, one short process each
    // ------------------------------------------------------------
    // Transfer complete; only a firmware write takes it down
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // Write collision; raised by a refused data write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_collision_flag_q <= 1'b0;
        end else begin
            write_collision_flag_q <= write_collision_flag_d;
        end
    end

    // Mode fault; another master pulled the select pin low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mflt_q <= 1'b0;
        end else begin
            mflt_q <= mflt_d;
        end
    end

    // Receive overrun; stays up so firmware learns a byte was lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovrn_q <= 1'b0;
        end else begin
            ovrn_q <= ovrn_d;
        end
    end

    // Buffer empty and its inverse as two flops, so the strobe to the
    // shift engine leaves straight from a register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txe_q     <= 1'b1;
            tx_full_q <= 1'b0;
        end else begin
            txe_q     <= txe_d;
            tx_full_q <= ~txe_d;
        end
    end

    // Firmware-writable settings
    // Master enable sits in a separate configuration register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `SCS_RST_MODE;
            en_q   <= 1'b0;
            mst_q  <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                mode_q <= wd[`SCS_BIT_MODE_HI:`SCS_BIT_MODE_LO];
                en_q   <= wd[`SCS_BIT_EN];
            end
            if (wr_cfg) begin
                mst_q <= wd[`SCS_BIT_MASTER];
            end
        end
    end

    // Transmit buffer keeps its byte on a collided write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txbuf_q <= `SCS_RST_DATA;
        end else if (data_ok) begin
            txbuf_q <= wd;
        end
    end

    // Receive buffer and its unread marker
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxbuf_q   <= `SCS_RST_DATA;
            rx_full_q <= 1'b0;
        end else begin
            if (ev_done) begin
                rxbuf_q <= rx_hold_q;
            end
            rx_full_q <= rx_full_d;
        end
    end

    // Pin synchroniser; pin is asynchronous to the system clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
        end else begin
            ss_s1_q <= slave_select_pin_i;
            ss_s2_q <= ss_s1_q;
        end
    end

    // Registered outputs; mode 0 and 1 leave the pin undriven
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
            ss_o_q  <= 1'b1;
            ss_oe_q <= 1'b0;
        end else begin
            rdata_q <= rd_mux;
            irq_q   <= irq_d;
            ss_o_q  <= pin_level;
            ss_oe_q <= drive_pin;
        end
    end

    // ------------------------------------------------------------
    // Output assignments, all from flip-flops
    // ------------------------------------------------------------
    assign sfr_rdata           = rdata_q;
    assign irq                 = irq_q;
    assign slave_select_pin_o  = ss_o_q;
    assign slave_select_pin_oe = ss_oe_q;
    assign port_enable         = en_q;
    assign master_enable       = mst_q;
    assign tx_byte             = txbuf_q;
    // Full flop, not an inverter on the empty flop
    assign tx_valid            = tx_full_q;
endmodule

// [tb/scs_ctrl_monitor.sv]
// Assertion checker for the serial port control block
`timescale 1ns/10ps
`include "scs_cfg.svh"
module scs_ctrl_monitor (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  reset_n,
    // Processor bus and interrupt
    input wire scs_pkg::scs_sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata,
    input wire logic                  irq_enable,
    input wire logic                  irq,
    // Pin and shift engine side
    input wire logic                  slave_select_pin_oe,
    input wire logic                  port_enable,
    input wire logic                  master_enable,
    input wire logic [7:0]            tx_byte,
    input wire logic                  tx_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Decoded firmware accesses
    wire wr_data = sfr_req.wr && sfr_req.addr == `SCS_ADDR_DATA;
    wire wr_ctrl = sfr_req.wr && sfr_req.addr == `SCS_ADDR_CTRL;
    wire rd_ctrl = sfr_req.rd && sfr_req.addr == `SCS_ADDR_CTRL;
    // Data write into a free buffer
    sequence free_write;
        wr_data && !tx_valid;
    endsequence
    // The byte lands whole, one cycle on
    sequence loaded;
        tx_valid && tx_byte == $past(sfr_req.wdata);
    endsequence
    load_ok_a: assert property (free_write |=> loaded) else $error("data write not loaded");
    collide_keep_a: assert property (wr_data && tx_valid |=> $stable(tx_byte)) else $error("collision overwrote");
    fill_src_a: assert property ($rose(tx_valid) |-> $past(wr_data)) else $error("buffer filled by itself");
    ctrl_read_a: assert property (rd_ctrl |=> sfr_rdata[`SCS_BIT_TXE] == !$past(tx_valid)
        && sfr_rdata[`SCS_BIT_EN] == $past(port_enable)) else $error("control read wrong");
    irq_gate_a: assert property (!irq_enable |=> !irq) else $error("irq while disabled");
    irq_hold_a: assert property (irq && irq_enable && !wr_ctrl && !$past(wr_ctrl) |=> irq)
        else $error("flag cleared by hardware");
    pin_idle_a: assert property (!port_enable && $past(!port_enable) |-> !slave_select_pin_oe)
        else $error("pin driven while off");
    reset_val_a: assert property ($rose(reset_n) |-> !tx_valid && !port_enable && !master_enable && !irq)
        else $error("reset values wrong");
endmodule
bind scs_ctrl scs_ctrl_monitor u_mon (.clk, .reset_n, .sfr_req, .sfr_rdata, .irq_enable, .irq,
    .slave_select_pin_oe, .port_enable, .master_enable, .tx_byte, .tx_valid);

// [tb/scs_link_model.sv]
// Behavioural shift engine that raises the link-domain events
`timescale 1ns/10ps
module scs_link_model (
    // Link clock
    input wire logic               link_clk,
    // Events and received byte
    output scs_pkg::scs_link_evt_s link_evt,
    output logic [7:0]             link_rx_byte
);
    // Idle: no events, byte line not left at a stale value
    initial begin
        link_evt = '0;
        link_rx_byte = 8'hFF;
    end
    // One event pulse, then two quiet cycles so the crossing never merges
    task automatic pulse(input logic [2:0] v);
        @(posedge link_clk);
        link_evt <= v;
        @(posedge link_clk);
        link_evt <= '0;
        repeat (2) @(posedge link_clk);
    endtask
    // A whole byte: load, final bit, completion
    task automatic xfer(input logic [7:0] b);
        pulse(3'b001);
        pulse(3'b010);
        link_rx_byte <= b;
        pulse(3'b100);
        link_rx_byte <= ~b;
    endtask
endmodule

// [tb/scs_ctrl_test.sv]
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`include "scs_cfg.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module scs_ctrl_test;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic                   clk, link_clk, reset_n, irq_enable, ss_ext;
    scs_pkg::scs_sfr_req_s  req;
    scs_pkg::scs_link_evt_s evt;
    logic [7:0]             rdata, rx_byte, tx_byte, d;
    logic                   irq, ss_o, ss_oe, pe, me, tx_valid;
    int                     fails, num_checks;
    // Pin level: the port wins while it drives
    wire pin = ss_oe ? ss_o : ss_ext;
    scs_ctrl dut (.clk, .reset_n, .link_clk, .link_rst_n(reset_n), .sfr_req(req), .sfr_rdata(rdata),
        .irq_enable, .irq, .link_evt(evt), .link_rx_byte(rx_byte), .slave_select_pin_i(pin),
        .slave_select_pin_o(ss_o), .slave_select_pin_oe(ss_oe), .port_enable(pe), .master_enable(me),
        .tx_byte, .tx_valid);
    scs_link_model lm (.link_clk, .link_evt(evt), .link_rx_byte(rx_byte));
    // Clocks, unrelated in phase
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        link_clk = 0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // ------------------------------------------------------------
    // Bus tasks, one access every two cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        req.wr = 1;
        req.addr = a;
        req.wdata = v;
        @(negedge clk);
        req.wr = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        req.rd = 1;
        req.addr = a;
        @(negedge clk);
        d = rdata;
        req.rd = 0;
    endtask
    // Bounded wait: 0 buffer empty, 1 interrupt high
    task automatic wait_for(input int k);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if (k == 0 ? tx_valid === 1'b0 : irq === 1'b1) return;
        end
        fails++;
        $display("[ERR] wait %0d exp 1 got 0", k);
        complete_run();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        reset_n = 0;
        req = '0;
        irq_enable = 0;
        ss_ext = 1;
        fails = 0;
        num_checks = 0;
        repeat (12) @(negedge clk);
        reset_n = 1;
        rd(`SCS_ADDR_CTRL);
        `CHK("ctrl reset", 8'h06, d)
        rd(8'h55);
        `CHK("unmapped", 8'h00, d)
        `CHK("master reset", 1'b0, me)
        $display("test reset done");
        // Every pin mode, port on
        for (int m = 0; m < 4; m++) begin
            wr(`SCS_ADDR_CTRL, 8'(m << 2) | 8'h01);
            repeat (2) @(negedge clk);
            `CHK("enable on", 1'b1, pe)
            `CHK("pin oe", m >= 2, ss_oe)
            if (m >= 2) `CHK("pin out", m == 3, ss_o)
            rd(`SCS_ADDR_CTRL);
            `CHK("ctrl mode", 8'(m << 2) | 8'h03, d)
        end
        wr(`SCS_ADDR_CTRL, 8'h08);
        repeat (2) @(negedge clk);
        `CHK("pin off", 1'b0, ss_oe)
        `CHK("enable off", 1'b0, pe)
        $display("test modes done");
        irq_enable = 1;
        wr(`SCS_ADDR_DATA, 8'h55);
        `CHK("tx byte", 8'h55, tx_byte)
        `CHK("tx full", 1'b1, tx_valid)
        wr(`SCS_ADDR_DATA, 8'hAA);
        `CHK("tx kept", 8'h55, tx_byte)
        rd(`SCS_ADDR_CTRL);
        `CHK("ctrl collide", 8'h48, d)
        wait_for(1);
        irq_enable = 0;
        repeat (2) @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        irq_enable = 1;
        wr(`SCS_ADDR_CTRL, 8'h09);
        repeat (3) @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test collision done");
        lm.xfer(8'h3C);
        wait_for(0);
        wait_for(1);
        rd(`SCS_ADDR_CTRL);
        `CHK("ctrl done", 8'h8B, d)
        rd(`SCS_ADDR_DATA);
        `CHK("rx byte", 8'h3C, d)
        repeat (20) @(negedge clk);
        rd(`SCS_ADDR_CTRL);
        `CHK("done sticky", 8'h8B, d)
        lm.xfer(8'hC3);
        lm.xfer(8'h5A);
        repeat (8) @(negedge clk);
        rd(`SCS_ADDR_CTRL);
        `CHK("ctrl overrun", 8'h9B, d)
        wr(`SCS_ADDR_CTRL, 8'h09);
        repeat (3) @(negedge clk);
        `CHK("irq flags off", 1'b0, irq)
        $display("test transfer done");
        wr(`SCS_ADDR_CTRL, 8'h05);
        repeat (4) @(negedge clk);
        wr(`SCS_ADDR_CFG, 8'h40);
        `CHK("master on", 1'b1, me)
        rd(`SCS_ADDR_CFG);
        `CHK("cfg read", 8'h40, d)
        rd(`SCS_ADDR_CTRL);
        `CHK("no fault high", 8'h07, d)
        ss_ext = 0;
        wait_for(1);
        rd(`SCS_ADDR_CTRL);
        `CHK("ctrl fault", 8'h27, d)
        ss_ext = 1;
        $display("test fault done");
        complete_run();
    end
endmodule
